/* hdl/fkm_defs.svh */
// Offsets, field positions, codes and reset values of the key/margin block.
// Assumes inclusion by bare name from the package and the design modules.
// Operation
// R1 - Key check: opcode 0x0c, keys at 001..100
// R2 - Key enable not 10: error, no compare
// R3 - Compare key words in order from 0x7f_ff00
// R4 - All four keys match: release security
// R5 - Mismatch: stay secure, error, lock till reset
// R6 - Key check index not 100: error
// R7 - Key check always ends with complete flag
// R8 - Software avoids running key check from key block
// R9 - User margin: opcode 0x0d, block, level at 001
// R10 - User levels 0000, 0001, 0002 only
// R11 - Stored block level steers later reads
// R12 - Valid user margin applied, then complete flag
// R13 - User margin errors: index, mode, block, level (code checks index, block and level, no mode)
// R14 - Field margin 0x0e only in special modes
// R15 - Field margin adds levels 0003 and 0004
// R16 - Valid field margin applied, then complete flag
// R17 - Field margin errors: index, mode, block, level
// R18 - Software uses field levels for factory verify
// R19 - Never set violation or verify flags
// R20 - Software writes nothing while command runs
`ifndef FKM_DEFS_SVH
`define FKM_DEFS_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define FKM_ADDR_STAT   3'h0
`define FKM_ADDR_PIDX   3'h1
`define FKM_ADDR_PDATA  3'h2
`define FKM_ADDR_SCFG   3'h3
`define FKM_ADDR_INFO   3'h4

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define FKM_ST_COMMAND_COMPLETE_FLAG     7
`define FKM_ST_ACCESS_ERROR_FLAG   5
`define FKM_ST_PROTECTION_VIOLATION_FLAG   4
`define FKM_ST_MGS1     1
`define FKM_ST_MGS0     0
`define FKM_KEY_ENABLE_FIELD_HI    7
`define FKM_KEY_ENABLE_FIELD_LO    6
`define FKM_KEY_ENABLE_FIELD_ON    2'h2
`define FKM_SCFG_RST    8'hff
`define FKM_NPRM        6

// ---------------------------------------------------------------------------
// Command codes, indices, levels, blocks
// ---------------------------------------------------------------------------
`define FKM_OP_KEY      8'h0c
`define FKM_OP_UMG      8'h0d
`define FKM_OP_FMG      8'h0e
`define FKM_IDX_KEY     3'h4
`define FKM_IDX_MARGIN  3'h1
`define FKM_LVL_UMAX    16'h0002
`define FKM_LVL_FMAX    16'h0004
`define FKM_KEY_BASE    23'h7fff00
`define FKM_NKEY        4
`define FKM_NBLK        4
`define FKM_BLK_BASE    7'h7c

`endif

/* hdl/fkm_key_cmp.sv */
// Sequential compare of four supplied key words against the stored key.
// Assumes supplied words stay still from start until done.
`timescale 1ns/10ps
`include "fkm_defs.svh"

module fkm_key_cmp
(
    input  wire logic        clk_sys_i,  // System clock
    input  wire logic        resetn_i,   // Async reset, low
    input  wire logic        start_i,    // Begin compare pulse
    input  wire logic [63:0] sup_key_i,  // Supplied keys, key 0 low
    input  wire logic [63:0] ref_key_i,  // Stored keys, key 0 low
    output logic             done_o,     // Compare finished pulse
    output logic             match_o     // All words equal
);
    import fkm_pkg::*;

    logic       busy_q, busy_d;
    logic [1:0] cnt_q,  cnt_d;
    logic       ok_q,   ok_d;
    logic       done_q, done_d;

    // -----------------------------------------------------------------------
    // One word a cycle: one comparator instead of four, four cycles spent
    // -----------------------------------------------------------------------
    always_comb
    begin
        busy_d = busy_q;
        cnt_d  = cnt_q;
        ok_d   = ok_q;
        done_d = 1'b0;
        if (start_i)
        begin
            busy_d = 1'b1;
            cnt_d  = 2'h0;
            ok_d   = 1'b1;
        end
        else if (busy_q)
        begin
            // Key n pairs with the stored word n after the base address
            ok_d  = ok_q & (sup_key_i[{cnt_q, 4'h0} +: 16] == ref_key_i[{cnt_q, 4'h0} +: 16]); // R3
            cnt_d = cnt_q + 2'h1;
            if (cnt_q == 2'(`FKM_NKEY - 1))
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    // Registers only
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            busy_q <= 1'b0;
            cnt_q  <= 2'h0;
            ok_q   <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            busy_q <= busy_d;
            cnt_q  <= cnt_d;
            ok_q   <= ok_d;
            done_q <= done_d;
        end
    end

    assign done_o  = done_q;
    assign match_o = ok_q;
endmodule : fkm_key_cmp

/* hdl/fkm_margin_store.sv */
// Per-block read margin levels, one register per flash block.
// Assumes write requests only come with a validated level.
`timescale 1ns/10ps
`include "fkm_defs.svh"

module fkm_margin_store
(
    input  wire logic             clk_sys_i,  // System clock
    input  wire logic             resetn_i,   // Async reset, low
    input  wire logic             wr_i,       // Store level pulse
    input  wire logic [1:0]       blk_i,      // Target block
    input  fkm_pkg::fkm_lvl_t     lvl_i,      // New level
    output fkm_pkg::fkm_lvls_t    lvls_o      // Levels of all blocks
);
    import fkm_pkg::*;

    // -----------------------------------------------------------------------
    // Level held until rewritten; drives the read path of that block
    // -----------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `FKM_NBLK; g++)
        begin : g_blk
            fkm_lvl_t lvl_q, lvl_d;

            // Only the addressed block takes the new level
            always_comb
            begin
                lvl_d = lvl_q;
                if (wr_i && (blk_i == 2'(g)))
                    lvl_d = lvl_i; // R11
            end

            always_ff @(posedge clk_sys_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    lvl_q <= 3'h0;
                else
                    lvl_q <= lvl_d;
            end

            assign lvls_o[g] = lvl_q;
        end
    endgenerate
endmodule : fkm_margin_store

/* hdl/fkm_pkg.sv */
// Types shared by the key/margin block and its leaf modules.
// Assumes the constants header sits beside it.
`include "fkm_defs.svh"

package fkm_pkg;
    // One-hot command sequencer states
    typedef enum logic [3:0]
    {
        FKM_ST_IDLE = 4'h1,
        FKM_ST_EXEC = 4'h2,
        FKM_ST_KEY  = 4'h4,
        FKM_ST_DONE = 4'h8
    } fkm_state_t;

    typedef logic [2:0]                     fkm_lvl_t;
    typedef logic [`FKM_NBLK-1:0][2:0]      fkm_lvls_t;
endpackage : fkm_pkg

/* hdl/fkm_top.sv */
// Command sequencer for key verification and read margin settings.
// Assumes a simple register port and a static stored key input.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "fkm_defs.svh"

module fkm_top
(
    input  wire logic         clk_sys_i,       // System clock, 125 MHz
    input  wire logic         resetn_i,        // Async reset, low
    input  wire logic [2:0]   addr_i,          // Register address
    input  wire logic [15:0]  wdata_i,         // Write data
    input  wire logic         wr_i,            // Write strobe
    input  wire logic         rd_i,            // Read strobe
    output logic      [15:0]  rdata_o,         // Read data, next cycle
    input  wire logic         special_mode_i,  // Special operating mode
    input  wire logic [63:0]  cmp_key_i,       // Stored key, key 0 low
    output logic              secure_o,        // Security engaged
    output logic              cmd_complete_o,  // Command complete flag
    output fkm_pkg::fkm_lvls_t margin_lvl_o    // Per-block margin levels
);
    import fkm_pkg::*;

    // -----------------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------------
    fkm_state_t  st_q, st_d;
    logic        command_complete_flag_q, command_complete_flag_d;
    logic        access_error_flag_q, access_error_flag_d;
    logic        secure_q, secure_d;
    logic        lock_q, lock_d;
    logic [2:0]  pidx_q, pidx_d;
    logic [7:0]  scfg_q, scfg_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] prm_q [`FKM_NPRM];
    logic        wr_stat, launch, acc_clr, acc_set, command_complete_flag_set;
    logic        kc_start, kc_done, kc_match, ms_wr;
    logic [7:0]  op;
    logic [6:0]  blk;
    logic [15:0] lvl_w;
    logic        blk_ok, key_err, umg_err, fmg_err;
    logic [63:0] sup_key;
    logic [15:0] stat_v;
    logic [15:0] info_v;

    // -----------------------------------------------------------------------
    // Command decode
    // -----------------------------------------------------------------------
    // Word 0 holds opcode high and block address low; word 1 the level
    assign op    = prm_q[0][15:8];  // R1 R9
    assign blk   = prm_q[0][6:0];   // R9
    assign lvl_w = prm_q[1];
    assign blk_ok = (blk >= `FKM_BLK_BASE);
    assign sup_key = {prm_q[4], prm_q[3], prm_q[2], prm_q[1]}; // R1 R3

    // Lock and enable are checked before any compare starts
    assign key_err = (pidx_q != `FKM_IDX_KEY)                        // R6
                   | (scfg_q[`FKM_KEY_ENABLE_FIELD_HI:`FKM_KEY_ENABLE_FIELD_LO] != `FKM_KEY_ENABLE_FIELD_ON) // R2
                   | lock_q;                                         // R5
    assign umg_err = (pidx_q != `FKM_IDX_MARGIN) | ~blk_ok
                   | (lvl_w > `FKM_LVL_UMAX);                        // R10 R13
    assign fmg_err = (pidx_q != `FKM_IDX_MARGIN) | ~special_mode_i   // R14
                   | ~blk_ok | (lvl_w > `FKM_LVL_FMAX);              // R15 R17

    // -----------------------------------------------------------------------
    // Register port strobes
    // -----------------------------------------------------------------------
    // Launch refused while an access error is still pending
    assign wr_stat = wr_i && (addr_i == `FKM_ADDR_STAT);
    assign launch  = wr_stat && wdata_i[`FKM_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_q && !access_error_flag_q;
    assign acc_clr = wr_stat && wdata_i[`FKM_ST_ACCESS_ERROR_FLAG];

    // -----------------------------------------------------------------------
    // Leaf units
    // -----------------------------------------------------------------------
    fkm_key_cmp u_key_cmp
    (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .start_i   (kc_start),
        .sup_key_i (sup_key),
        .ref_key_i (cmp_key_i),
        .done_o    (kc_done),
        .match_o   (kc_match)
    );

    fkm_margin_store u_margin
    (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_i      (ms_wr),
        .blk_i     (blk[1:0]),
        .lvl_i     (lvl_w[2:0]),
        .lvls_o    (margin_lvl_o)
    );

    // -----------------------------------------------------------------------
    // Sequencer, flags and security state
    // -----------------------------------------------------------------------
    always_comb
    begin
        st_d     = st_q;
        secure_d = secure_q;
        lock_d   = lock_q;
        acc_set  = 1'b0;
        command_complete_flag_set = 1'b0;
        kc_start = 1'b0;
        ms_wr    = 1'b0;
        case (st_q)
            FKM_ST_IDLE:
            begin
                if (launch)
                    st_d = FKM_ST_EXEC;
            end
            FKM_ST_EXEC:
            begin
                st_d = FKM_ST_DONE;
                case (op)
                    `FKM_OP_KEY:
                    begin
                        acc_set = key_err;     // R2 R5 R6
                        kc_start = !key_err;   // R3
                        if (!key_err)
                            st_d = FKM_ST_KEY;
                    end
                    `FKM_OP_UMG:
                    begin
                        acc_set = umg_err;     // R13
                        ms_wr   = !umg_err;    // R12
                    end
                    `FKM_OP_FMG:
                    begin
                        acc_set = fmg_err;     // R17
                        ms_wr   = !fmg_err;    // R16
                    end
                    default:
                        acc_set = 1'b1;
                endcase
            end
            FKM_ST_KEY:
            begin
                if (kc_done)
                begin
                    st_d = FKM_ST_DONE;
                    if (kc_match)
                        secure_d = 1'b0;       // R4
                    else
                    begin
                        lock_d  = 1'b1;        // R5
                        acc_set = 1'b1;        // R5
                    end
                end
            end
            FKM_ST_DONE:
            begin
                command_complete_flag_set = 1'b1;               // R7 R12 R16
                st_d     = FKM_ST_IDLE;
            end
            default:
                st_d = FKM_ST_IDLE;
        endcase
        // A set arriving with a software clear wins
        access_error_flag_d = (access_error_flag_q & ~acc_clr) | acc_set;
        command_complete_flag_d   = (command_complete_flag_q & ~launch) | command_complete_flag_set;
        // Index, config and parameter writes during a command are dropped, never half applied
        pidx_d = pidx_q;
        scfg_d = scfg_q;
        if (wr_i && command_complete_flag_q && (addr_i == `FKM_ADDR_PIDX))
            pidx_d = wdata_i[2:0];             // R20
        if (wr_i && command_complete_flag_q && (addr_i == `FKM_ADDR_SCFG))
            scfg_d = wdata_i[7:0];             // R20
    end

    // Registers only
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q     <= FKM_ST_IDLE;
            command_complete_flag_q   <= 1'b1;
            access_error_flag_q <= 1'b0;
            secure_q <= 1'b1;
            lock_q   <= 1'b0;
            pidx_q   <= 3'h0;
            scfg_q   <= `FKM_SCFG_RST;
        end
        else
        begin
            st_q     <= st_d;
            command_complete_flag_q   <= command_complete_flag_d;
            access_error_flag_q <= access_error_flag_d;
            secure_q <= secure_d;
            lock_q   <= lock_d;
            pidx_q   <= pidx_d;
            scfg_q   <= scfg_d;
        end
    end

    // -----------------------------------------------------------------------
    // Parameter words, written at the current index
    // -----------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `FKM_NPRM; g++)
        begin : g_prm
            logic [15:0] prm_d;

            always_comb
            begin
                prm_d = prm_q[g];
                if (wr_i && command_complete_flag_q && (addr_i == `FKM_ADDR_PDATA) && (pidx_q == 3'(g)))
                    prm_d = wdata_i;           // R20
            end

            always_ff @(posedge clk_sys_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    prm_q[g] <= 16'h0000;
                else
                    prm_q[g] <= prm_d;
            end
        end
    endgenerate

    // -----------------------------------------------------------------------
    // Read port: data only in the cycle after the strobe
    // -----------------------------------------------------------------------
    always_comb
    begin
        // Violation and verify flags stay zero for these commands
        stat_v = 16'h0000;                     // R19
        stat_v[`FKM_ST_COMMAND_COMPLETE_FLAG]   = command_complete_flag_q;
        stat_v[`FKM_ST_ACCESS_ERROR_FLAG] = access_error_flag_q;
        info_v = {13'h0000, special_mode_i, lock_q, secure_q};
        rdata_d = 16'h0000;
        if (rd_i)
        begin
            case (addr_i)
                `FKM_ADDR_STAT:  rdata_d = stat_v;
                `FKM_ADDR_PIDX:  rdata_d = {13'h0000, pidx_q};
                `FKM_ADDR_PDATA: rdata_d = (pidx_q < 3'(`FKM_NPRM)) ? prm_q[pidx_q] : 16'h0000;
                `FKM_ADDR_SCFG:  rdata_d = {8'h00, scfg_q};
                `FKM_ADDR_INFO:  rdata_d = info_v;
                default:         rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata_q <= 16'h0000;
        else
            rdata_q <= rdata_d;
    end

    assign rdata_o        = rdata_q;
    assign secure_o       = secure_q;
    assign cmd_complete_o = command_complete_flag_q;

    // -----------------------------------------------------------------------
    // Assertions and covers
    // -----------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    AST_KEY_START: assert property ( // R1
        st_q == FKM_ST_EXEC && op == `FKM_OP_KEY && !key_err
        |=> st_q == FKM_ST_KEY)
        else $error("key command did not start compare");

    AST_KEY_ENABLE_FIELD_OFF: assert property ( // R2
        st_q == FKM_ST_EXEC && op == `FKM_OP_KEY
        && scfg_q[`FKM_KEY_ENABLE_FIELD_HI:`FKM_KEY_ENABLE_FIELD_LO] != `FKM_KEY_ENABLE_FIELD_ON
        |=> access_error_flag_q && st_q == FKM_ST_DONE ##1 command_complete_flag_q)
        else $error("disabled key command not rejected");

    AST_RELEASE: assert property ( // R4
        st_q == FKM_ST_KEY && kc_done && kc_match |=> !secure_o)
        else $error("matching keys did not release security");

    AST_MISMATCH: assert property ( // R5
        st_q == FKM_ST_KEY && kc_done && !kc_match
        |=> access_error_flag_q && lock_q && secure_o == $past(secure_o))
        else $error("key mismatch handled wrongly");

    AST_LOCK_ABORT: assert property ( // R5
        lock_q && st_q == FKM_ST_EXEC && op == `FKM_OP_KEY
        |=> st_q == FKM_ST_DONE && access_error_flag_q)
        else $error("locked key command not aborted");

    AST_KEY_INDEX: assert property ( // R6
        st_q == FKM_ST_EXEC && op == `FKM_OP_KEY && pidx_q != `FKM_IDX_KEY
        |=> access_error_flag_q && st_q != FKM_ST_KEY)
        else $error("wrong key index not rejected");

    AST_COMPLETE: assert property ( // R7
        launch |=> !cmd_complete_o ##[1:8] cmd_complete_o)
        else $error("command complete flag not set in time");

    AST_UMG_APPLY: assert property ( // R12
        st_q == FKM_ST_EXEC && op == `FKM_OP_UMG && !umg_err
        |=> margin_lvl_o[$past(blk[1:0])] == $past(lvl_w[2:0]) ##1 cmd_complete_o)
        else $error("user margin not applied before completion");

    AST_UMG_ERR: assert property ( // R13
        st_q == FKM_ST_EXEC && op == `FKM_OP_UMG && umg_err
        |=> access_error_flag_q && $stable(margin_lvl_o))
        else $error("bad user margin command not rejected");

    AST_FMG_MODE: assert property ( // R14
        st_q == FKM_ST_EXEC && op == `FKM_OP_FMG && !special_mode_i
        |=> access_error_flag_q && $stable(margin_lvl_o))
        else $error("field margin ran outside special mode");

    AST_FMG_APPLY: assert property ( // R16
        st_q == FKM_ST_EXEC && op == `FKM_OP_FMG && !fmg_err
        |=> margin_lvl_o[$past(blk[1:0])] == $past(lvl_w[2:0]))
        else $error("field margin not applied");

    AST_NO_VIOL: assert property ( // R19
        rd_i && addr_i == `FKM_ADDR_STAT
        |=> rdata_o[`FKM_ST_PROTECTION_VIOLATION_FLAG] == 1'b0 && rdata_o[`FKM_ST_MGS1:`FKM_ST_MGS0] == 2'h0)
        else $error("violation or verify flag reported set");

    COV_KEY_OK:  cover property (st_q == FKM_ST_KEY && kc_done && kc_match);
    COV_KEY_BAD: cover property (st_q == FKM_ST_KEY && kc_done && !kc_match);
    COV_UMG_OK:  cover property (st_q == FKM_ST_EXEC && op == `FKM_OP_UMG && !umg_err);
    COV_FMG_OK:  cover property (st_q == FKM_ST_EXEC && op == `FKM_OP_FMG && !fmg_err);
endmodule : fkm_top

/* testbench/fkm_tb.sv */
// ---------------------------------------------------------------------------
// Testbench for the key check and read margin command sequencer
// ---------------------------------------------------------------------------
// Assumes the package and header of hdl/ are compiled first.
`timescale 1ns/10ps
`include "fkm_defs.svh"

module testbench;
    import fkm_pkg::*;

    logic        clk_sys_i;
    logic        resetn_i;
    logic [2:0]  addr_i;
    logic [15:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [15:0] rdata_o;
    logic        special_mode_i;
    logic [63:0] cmp_key_i;
    logic        secure_o;
    logic        cmd_complete_o;
    fkm_lvls_t   margin_lvl_o;
    fkm_lvls_t   exp_lvl;
    logic [15:0] rd_val;
    int          num_errors;
    int          cmp_count;
    logic [63:0] good_key;

    fkm_top dut_u
    (
        .clk_sys_i      (clk_sys_i),
        .resetn_i       (resetn_i),
        .addr_i         (addr_i),
        .wdata_i        (wdata_i),
        .wr_i           (wr_i),
        .rd_i           (rd_i),
        .rdata_o        (rdata_o),
        .special_mode_i (special_mode_i),
        .cmp_key_i      (cmp_key_i),
        .secure_o       (secure_o),
        .cmd_complete_o (cmd_complete_o),
        .margin_lvl_o   (margin_lvl_o)
    );

    // 125 MHz system clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ---------------------------------------------------------------------------
    // Bus and check tasks
    // ---------------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1 rd_val = rdata_o;
    endtask : rd

    // Loads five parameter words, launches, waits bounded, checks status
    task automatic cmd(input logic [7:0] op, input logic [6:0] blk, input logic [2:0] idx,
                       input logic [63:0] prm, input logic err, input int cyc);
        int n;
        wr(`FKM_ADDR_PIDX, 16'h0000);
        wr(`FKM_ADDR_PDATA, {op, 1'b0, blk});
        for (int i = 1; i < 5; i++)
        begin
            wr(`FKM_ADDR_PIDX, 16'(i));
            wr(`FKM_ADDR_PDATA, prm[(i-1)*16 +: 16]);
        end
        wr(`FKM_ADDR_PIDX, {13'h0000, idx});
        wr(`FKM_ADDR_STAT, 16'h0080);
        #1 chk({15'h0000, cmd_complete_o}, 16'h0000, "busy after launch");
        n = 0;
        // No register write until the flag is back, bounded wait
        while (cmd_complete_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        chk(16'(n), 16'(cyc), "edges to completion");
        rd(`FKM_ADDR_STAT);
        chk(rd_val, err ? 16'h00a0 : 16'h0080, "status after command");
        // Launches are refused while the error is pending, so clear it here
        if (err)
            wr(`FKM_ADDR_STAT, 16'h0020);
        chk({4'h0, margin_lvl_o}, {4'h0, exp_lvl}, "block levels");
    endtask : cmd

    task automatic do_reset;
        resetn_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        exp_lvl = '0;
    endtask : do_reset

    task automatic conclude;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Watchdog, far beyond the thousand or so cycles the tests need
    initial
    begin
        #200000;
        num_errors++;
        conclude();
    end

    // ---------------------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------------------
    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        resetn_i = 1'b0;
        addr_i = 3'h0;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        special_mode_i = 1'b0;
        good_key = 64'h4d4c_3b2a_2910_1f0e;
        cmp_key_i = good_key;
        do_reset();
        rd(`FKM_ADDR_STAT);
        chk(rd_val, 16'h0080, "status reset");
        rd(`FKM_ADDR_SCFG);
        chk(rd_val, 16'h00ff, "config reset");
        rd(3'h5);
        chk(rd_val, 16'h0000, "unmapped read");
        // Every user level on every block; blocks 0 and 3 both end at level 0
        for (int b = 0; b < 4; b++)
            for (int l = 0; l < 3; l++)
            begin
                exp_lvl[b] = 3'((b + l + 1) % 3);
                cmd(`FKM_OP_UMG, 7'(8'h7c + b), 3'h1, 64'(exp_lvl[b]), 1'b0, 2);
            end
        cmd(`FKM_OP_UMG, 7'h7d, 3'h1, 64'h3, 1'b1, 2);
        cmd(`FKM_OP_UMG, 7'h7d, 3'h0, 64'h1, 1'b1, 2);
        cmd(`FKM_OP_UMG, 7'h7b, 3'h1, 64'h1, 1'b1, 2);
        cmd(`FKM_OP_FMG, 7'h7e, 3'h1, 64'h1, 1'b1, 2);
        // Unknown opcode is refused with an access error
        cmd(8'h0b, 7'h7c, 3'h0, 64'h0, 1'b1, 2);
        // Field levels need special mode; factory verify use only
        @(posedge clk_sys_i) special_mode_i <= 1'b1;
        for (int l = 0; l < 5; l++)
        begin
            exp_lvl[2] = 3'(l);
            cmd(`FKM_OP_FMG, 7'h7e, 3'h1, 64'(l), 1'b0, 2);
        end
        cmd(`FKM_OP_FMG, 7'h7e, 3'h1, 64'h5, 1'b1, 2);
        cmd(`FKM_OP_FMG, 7'h7e, 3'h2, 64'h1, 1'b1, 2);
        cmd(`FKM_OP_FMG, 7'h00, 3'h1, 64'h1, 1'b1, 2);
        @(posedge clk_sys_i) special_mode_i <= 1'b0;
        // Key check disabled, then enabled with a bad index
        cmd(`FKM_OP_KEY, 7'h00, 3'h4, good_key, 1'b1, 2);
        wr(`FKM_ADDR_SCFG, 16'h0080);
        cmd(`FKM_OP_KEY, 7'h00, 3'h3, good_key, 1'b1, 2);
        rd(`FKM_ADDR_PIDX);
        chk(rd_val, 16'h0003, "index readback");
        rd(`FKM_ADDR_PDATA);
        chk(rd_val, 16'h3b2a, "key 2 at index 011");
        // Last key word wrong locks the command out until reset
        cmd(`FKM_OP_KEY, 7'h00, 3'h4, good_key ^ 64'h8000_0000_0000_0000, 1'b1, 7);
        chk({15'h0000, secure_o}, 16'h0001, "still secure");
        cmd(`FKM_OP_KEY, 7'h00, 3'h4, good_key, 1'b1, 2);
        rd(`FKM_ADDR_INFO);
        chk(rd_val, 16'h0003, "secure and locked");
        // Reset between commands clears lock and levels
        do_reset();
        chk({4'h0, margin_lvl_o}, 16'h0000, "levels after reset");
        wr(`FKM_ADDR_SCFG, 16'h0080);
        // Issued by the bench, never from code in the key block
        cmd(`FKM_OP_KEY, 7'h00, 3'h4, good_key, 1'b0, 7);
        chk({15'h0000, secure_o}, 16'h0000, "security released");
        rd(`FKM_ADDR_INFO);
        chk(rd_val, 16'h0000, "info after release");
        conclude();
    end
endmodule : testbench
